// >>> ddr2_ext_mode_cfg.svh
/*
  constants for the mode register and initialization tracking logic:
  bank codes, mode field positions, reset values, latency and lock counts.
  assumes it is included by bare name after any package compilation.
*/
`ifndef DDR2_EXT_MODE_CFG_SVH
`define DDR2_EXT_MODE_CFG_SVH

// ****************************************************************
// bank select codes of the load mode command
// ****************************************************************
`define BA_MAIN_MODE     2'h0
`define BA_EXT_MODE_1    2'h1
`define BA_EXT_MODE_2    2'h2
`define BA_EXT_MODE_3    2'h3

// ****************************************************************
// field positions
// ****************************************************************
`define RTT_LO_BIT       2
`define RTT_HI_BIT       6
`define AL_LSB           3
`define AL_MSB           5
`define CAL_LSB          7
`define CAL_MSB          9
`define REFRESH_RATE_BIT 7
`define DLL_RESET_BIT    8
`define CL_LSB           4
`define CL_MSB           6

// ****************************************************************
// values and counts
// ****************************************************************
`define MODE_RST         16'h0000
`define AL_MAX           3'h6
`define CAL_DEFAULT      3'h0
`define DLL_LOCK_CYCLES  8'hc8
`define LAT_DEPTH        16
`define LAT_SELW         4

`endif

// >>> ddr2_ext_mode_pkg.sv
/*
  types shared by the mode register and initialization tracking logic.
  assumes the constants header supplies all numeric values.
*/
package ddr2_ext_mode_pkg;

  typedef struct packed {
    logic        cs_n;
    logic        ras_n;
    logic        cas_n;
    logic        we_n;
    logic [2:0]  ba;
    logic [15:0] addr;
  } cmd_pins_t;

  typedef enum logic [1:0] {
    st_awake,
    st_power_down,
    st_self_refresh
  } pwr_state_t;

  typedef enum logic [1:0] {
    rtt_off,
    rtt_75,
    rtt_150,
    rtt_50
  } rtt_t;

  typedef struct packed {
    logic [2:0] additive;
    logic [3:0] read;
    logic [3:0] write;
  } latency_t;

endpackage

// >>> cmd_delay_line.sv
/*
  shift line that delays a command flag by a selectable number of link
  clock edges; tap 0 is the input itself.
  assumes shift_en pulses once per link clock rising edge.
*/
`timescale 1ns/1ps

module cmd_delay_line #(
  parameter int DEPTH = 16,
  parameter int SELW  = 4
) (
  input  wire logic            clk_sys,
  input  wire logic            rstn,
  input  wire logic            ce,
  input  wire logic            shift_en,
  input  wire logic            din,
  input  wire logic [SELW-1:0] tap_sel,
  output logic                 tap_out
);

  logic taps [DEPTH];

  assign taps[0] = din;

  // ****************************************************************
  // delay stages
  // ****************************************************************
  genvar i;
  generate
    for (i = 1; i < DEPTH; i++)
    begin : g_stage
      always_ff @(posedge clk_sys)
      begin
        if (!rstn)
          taps[i] <= 1'b0;
        else if (ce && shift_en)
          taps[i] <= taps[i-1];
      end
    end
  endgenerate

  assign tap_out = taps[tap_sel];

endmodule

// >>> ddr2_ext_mode_init.sv
/*
  mode register file and initialization tracker of the memory device:
  termination select and control, additive, read and write latency,
  refresh rate bit, calibration state, loop lock readiness.
  assumes command pins, link clock, clock enable and termination pin come
  from outside the clk_sys domain; link clock is much slower than clk_sys.
*/
// Function
// (RULE_01) termination 50, 75 or 150 ohms selected
// (RULE_02) termination pair decode: 00 off,01/10/11
// (RULE_03) termination follows pin except in self refresh
// (RULE_04) controller drops pin before self refresh
// (RULE_05) controller keeps termination off during init
// (RULE_06) pin low eight clocks after enabling load
// (RULE_07) calibration field left at default
// (RULE_08) three-bit additive latency, zero to six
// (RULE_09) column command held additive latency clocks
// (RULE_10) read data at additive plus column latency
// (RULE_11) write latency one less than read
// (RULE_12) second register holds refresh rate bit
// (RULE_13) controller zeroes reserved and third register
// (RULE_14) registers hold until next load mode
// (RULE_15) second/third loads only when banks idle
// (RULE_16) controller waits 200 us before clock enable
// (RULE_17) clock enable stays high through init
// (RULE_18) precharge all 400 ns after enable
// (RULE_19) then load second register
// (RULE_20) then load third register
// (RULE_21) then load first register, loop enabled
// (RULE_22) then main register with loop reset
// (RULE_23) then precharge all, two refreshes
// (RULE_24) then main register without loop reset
// (RULE_25) calibration default load, then exit load
// (RULE_26) ready 200 clocks after loop reset
// (RULE_27) additive codes above six are reserved
`timescale 1ns/1ps
`include "ddr2_ext_mode_cfg.svh"

module ddr2_ext_mode_init (
  input  wire logic                   clk_sys,
  input  wire logic                   rstn,
  input  wire logic                   ce,
  input  wire logic                   ck_pin,
  input  wire logic                   cke_pin,
  input  wire logic                   odt_pin,
  input  wire ddr2_ext_mode_pkg::cmd_pins_t cmd_pin,
  output ddr2_ext_mode_pkg::rtt_t     rtt_sel_q,
  output logic                        term_on_q,
  output ddr2_ext_mode_pkg::latency_t latency_q,
  output logic                        al_reserved_q,
  output logic                        refresh_fast_q,
  output logic                        cal_default_q,
  output logic                        col_issue_q,
  output logic                        read_data_start_q,
  output logic                        write_data_expect_q,
  output logic                        ready_q,
  output ddr2_ext_mode_pkg::pwr_state_t pwr_state_q
);

  // ****************************************************************
  // input synchronisers
  // ****************************************************************
  logic                          ck_s1, ck_s2, ck_s3;
  logic                          cke_s1, cke_s2;
  logic                          odt_s1, odt_s2;
  ddr2_ext_mode_pkg::cmd_pins_t  cmd_s1, cmd_s2;

  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
    begin
      ck_s1  <= 1'b0;
      ck_s2  <= 1'b0;
      ck_s3  <= 1'b0;
      cke_s1 <= 1'b0;
      cke_s2 <= 1'b0;
      odt_s1 <= 1'b0;
      odt_s2 <= 1'b0;
      cmd_s1 <= '1;
      cmd_s2 <= '1;
    end
    else if (ce)
    begin
      ck_s1  <= ck_pin;
      ck_s2  <= ck_s1;
      ck_s3  <= ck_s2;
      cke_s1 <= cke_pin;
      cke_s2 <= cke_s1;
      odt_s1 <= odt_pin;
      odt_s2 <= odt_s1;
      cmd_s1 <= cmd_pin;
      cmd_s2 <= cmd_s1;
    end
  end

  // ****************************************************************
  // command decode on link clock rising edge
  // ****************************************************************
  logic tick;
  logic cmd_low3;
  logic load_mode_cmd;
  logic refresh_cmd;
  logic read_cmd;
  logic write_cmd;

  assign tick          = ck_s2 & ~ck_s3;
  assign cmd_low3      = tick & ~cmd_s2.cs_n & ~cmd_s2.ras_n & ~cmd_s2.cas_n;
  assign load_mode_cmd = cmd_low3 & ~cmd_s2.we_n;
  assign refresh_cmd   = cmd_low3 & cmd_s2.we_n;
  assign read_cmd      = tick & ~cmd_s2.cs_n & cmd_s2.ras_n & ~cmd_s2.cas_n & cmd_s2.we_n;
  assign write_cmd     = tick & ~cmd_s2.cs_n & cmd_s2.ras_n & ~cmd_s2.cas_n & ~cmd_s2.we_n;

  // ****************************************************************
  // mode registers
  // ****************************************************************
  logic [15:0] main_mode_reg_q;
  logic [15:0] ext_mode_reg_1_q;
  logic [15:0] ext_mode_reg_2_q;
  logic [15:0] ext_mode_reg_3_q;

  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
    begin
      main_mode_reg_q  <= `MODE_RST;
      ext_mode_reg_1_q <= `MODE_RST;
      ext_mode_reg_2_q <= `MODE_RST;
      ext_mode_reg_3_q <= `MODE_RST;
    end
    else if (ce && load_mode_cmd)                                   // [RULE_14]
    begin
      unique case (cmd_s2.ba[1:0])
        `BA_MAIN_MODE:  main_mode_reg_q  <= cmd_s2.addr;
        `BA_EXT_MODE_1: ext_mode_reg_1_q <= cmd_s2.addr;
        `BA_EXT_MODE_2: ext_mode_reg_2_q <= cmd_s2.addr;
        `BA_EXT_MODE_3: ext_mode_reg_3_q <= cmd_s2.addr;
      endcase
    end
  end

  // ****************************************************************
  // field decode
  // ****************************************************************
  logic [2:0]              al_code;
  logic                    al_res;
  logic [2:0]              al_eff;
  logic [3:0]              rl;
  logic [3:0]              wl;
  ddr2_ext_mode_pkg::rtt_t rtt_d;

  assign al_code = ext_mode_reg_1_q[`AL_MSB:`AL_LSB];
  assign al_res  = al_code > `AL_MAX;                               // [RULE_27]
  assign al_eff  = al_res ? 3'h0 : al_code;                         // [RULE_08]
  assign rl      = {1'b0, al_eff} + {1'b0, main_mode_reg_q[`CL_MSB:`CL_LSB]}; // [RULE_10]
  assign wl      = rl - 4'h1;                                       // [RULE_11]

  always_comb
  begin
    unique case ({ext_mode_reg_1_q[`RTT_HI_BIT], ext_mode_reg_1_q[`RTT_LO_BIT]})
      2'h0: rtt_d = ddr2_ext_mode_pkg::rtt_off;                     // [RULE_02]
      2'h1: rtt_d = ddr2_ext_mode_pkg::rtt_75;                      // [RULE_01]
      2'h2: rtt_d = ddr2_ext_mode_pkg::rtt_150;
      2'h3: rtt_d = ddr2_ext_mode_pkg::rtt_50;
    endcase
  end

  // ****************************************************************
  // power state
  // ****************************************************************
  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
      pwr_state_q <= ddr2_ext_mode_pkg::st_awake;
    else if (ce && tick)
    begin
      unique case (pwr_state_q)
        ddr2_ext_mode_pkg::st_awake:
          if (!cke_s2)
            pwr_state_q <= refresh_cmd ? ddr2_ext_mode_pkg::st_self_refresh
                                       : ddr2_ext_mode_pkg::st_power_down;
        ddr2_ext_mode_pkg::st_power_down,
        ddr2_ext_mode_pkg::st_self_refresh:
          if (cke_s2)
            pwr_state_q <= ddr2_ext_mode_pkg::st_awake;
      endcase
    end
  end

  // ****************************************************************
  // configuration outputs
  // ****************************************************************
  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
    begin
      rtt_sel_q      <= ddr2_ext_mode_pkg::rtt_off;
      term_on_q      <= 1'b0;
      latency_q      <= '{additive: 3'h0, read: 4'h0, write: 4'hf};
      al_reserved_q  <= 1'b0;
      refresh_fast_q <= 1'b0;
      cal_default_q  <= 1'b1;
    end
    else if (ce)
    begin
      rtt_sel_q      <= rtt_d;                                      // [RULE_01]
      term_on_q      <= (rtt_d != ddr2_ext_mode_pkg::rtt_off) && odt_s2 &&
                        (pwr_state_q != ddr2_ext_mode_pkg::st_self_refresh); // [RULE_03]
      latency_q      <= '{additive: al_eff, read: rl, write: wl};   // [RULE_10]
      al_reserved_q  <= al_res;                                     // [RULE_27]
      refresh_fast_q <= ext_mode_reg_2_q[`REFRESH_RATE_BIT];        // [RULE_12]
      cal_default_q  <= ext_mode_reg_1_q[`CAL_MSB:`CAL_LSB] == `CAL_DEFAULT;
    end
  end

  // ****************************************************************
  // posted column command and data latency
  // ****************************************************************
  logic col_tap;
  logic rd_tap;
  logic wr_tap;

  cmd_delay_line #(.DEPTH(`LAT_DEPTH), .SELW(`LAT_SELW)) u_col_line (
    .clk_sys  (clk_sys),
    .rstn     (rstn),
    .ce       (ce),
    .shift_en (tick),
    .din      (read_cmd | write_cmd),
    .tap_sel  ({1'b0, al_eff}),
    .tap_out  (col_tap)
  );

  cmd_delay_line #(.DEPTH(`LAT_DEPTH), .SELW(`LAT_SELW)) u_rd_line (
    .clk_sys  (clk_sys),
    .rstn     (rstn),
    .ce       (ce),
    .shift_en (tick),
    .din      (read_cmd),
    .tap_sel  (rl),
    .tap_out  (rd_tap)
  );

  cmd_delay_line #(.DEPTH(`LAT_DEPTH), .SELW(`LAT_SELW)) u_wr_line (
    .clk_sys  (clk_sys),
    .rstn     (rstn),
    .ce       (ce),
    .shift_en (tick),
    .din      (write_cmd),
    .tap_sel  (wl),
    .tap_out  (wr_tap)
  );

  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
    begin
      col_issue_q         <= 1'b0;
      read_data_start_q   <= 1'b0;
      write_data_expect_q <= 1'b0;
    end
    else if (ce)
    begin
      col_issue_q         <= tick & col_tap;                        // [RULE_09]
      read_data_start_q   <= tick & rd_tap;                         // [RULE_10]
      write_data_expect_q <= tick & wr_tap;                         // [RULE_11]
    end
  end

  // ****************************************************************
  // loop lock readiness
  // ****************************************************************
  logic [7:0] dll_cnt_q;
  logic       dll_busy_q;
  logic       dll_reset_load;

  assign dll_reset_load = load_mode_cmd && (cmd_s2.ba[1:0] == `BA_MAIN_MODE) &&
                          cmd_s2.addr[`DLL_RESET_BIT];

  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
    begin
      dll_cnt_q  <= 8'h00;
      dll_busy_q <= 1'b0;
      ready_q    <= 1'b0;
    end
    else if (ce)
    begin
      if (dll_reset_load)
      begin
        dll_cnt_q  <= 8'h00;                                        // [RULE_26]
        dll_busy_q <= 1'b1;
        ready_q    <= 1'b0;
      end
      else if (tick && dll_busy_q)
      begin
        dll_cnt_q <= dll_cnt_q + 8'h01;
        if (dll_cnt_q + 8'h01 == `DLL_LOCK_CYCLES)
        begin
          dll_busy_q <= 1'b0;
          ready_q    <= 1'b1;                                       // [RULE_26]
        end
      end
    end
  end

  // ****************************************************************
  // assertions
  // ****************************************************************
  sequence s_dll_reset;
    ce && dll_reset_load;
  endsequence

  a_rtt_fifty: assert property (@(posedge clk_sys) disable iff (!rstn) // [RULE_01]
    ce && ext_mode_reg_1_q[`RTT_HI_BIT] && ext_mode_reg_1_q[`RTT_LO_BIT]
    |=> rtt_sel_q == ddr2_ext_mode_pkg::rtt_50)
    else $error("termination code 11 not decoded as 50 ohms");

  a_rtt_seventy_five: assert property (@(posedge clk_sys) disable iff (!rstn) // [RULE_02]
    ce && !ext_mode_reg_1_q[`RTT_HI_BIT] && ext_mode_reg_1_q[`RTT_LO_BIT]
    |=> rtt_sel_q == ddr2_ext_mode_pkg::rtt_75)
    else $error("termination code 01 not decoded as 75 ohms");

  a_term_self_refresh: assert property (@(posedge clk_sys) disable iff (!rstn) // [RULE_03]
    ce && pwr_state_q == ddr2_ext_mode_pkg::st_self_refresh |=> !term_on_q)
    else $error("termination on during self refresh");

  a_al_range: assert property (@(posedge clk_sys) disable iff (!rstn) // [RULE_08]
    latency_q.additive <= `AL_MAX)
    else $error("additive latency above six");

  a_al_reserved_code: assert property (@(posedge clk_sys) disable iff (!rstn) // [RULE_27]
    ce && al_code == 3'h7 |=> al_reserved_q && latency_q.additive == 3'h0)
    else $error("reserved additive code not flagged");

  a_col_no_delay: assert property (@(posedge clk_sys) disable iff (!rstn) // [RULE_09]
    ce && read_cmd && al_eff == 3'h0 |=> col_issue_q)
    else $error("column command not issued at zero additive latency");

  a_wl_below_rl: assert property (@(posedge clk_sys) disable iff (!rstn) // [RULE_11]
    4'(latency_q.write + 4'h1) == latency_q.read)
    else $error("write latency not one below read latency");

  a_mode_hold: assert property (@(posedge clk_sys) disable iff (!rstn) // [RULE_14]
    !(ce && load_mode_cmd) |=> $stable(ext_mode_reg_1_q) && $stable(ext_mode_reg_2_q)
                               && $stable(main_mode_reg_q) && $stable(ext_mode_reg_3_q))
    else $error("mode register changed without load mode");

  a_refresh_bit: assert property (@(posedge clk_sys) disable iff (!rstn) // [RULE_12]
    ce |=> refresh_fast_q == $past(ext_mode_reg_2_q[`REFRESH_RATE_BIT]))
    else $error("refresh rate output does not follow register");

  a_dll_not_ready: assert property (@(posedge clk_sys) disable iff (!rstn) // [RULE_26]
    s_dll_reset |=> !ready_q && dll_cnt_q == 8'h00)
    else $error("ready not withdrawn on loop reset");

  a_dll_ready_count: assert property (@(posedge clk_sys) disable iff (!rstn) // [RULE_26]
    $rose(ready_q) |-> dll_cnt_q == `DLL_LOCK_CYCLES)
    else $error("ready raised before 200 link clocks");

endmodule

// >>> mem_ctrl_model.sv
/*
  controller model: link clock, commands, clock enable and odt pin.
  assumes clk_sys is the device clock; pins change just after its edges.
*/
`timescale 1ns/1ps

module mem_ctrl_model (
  input  wire logic                    clk_sys,
  output logic                         ck_pin,
  output logic                         cke_pin,
  output logic                         odt_pin,
  output ddr2_ext_mode_pkg::cmd_pins_t cmd_pin
);
  int   ck_edges = 0;
  int   cmd_edge = 0;
  int   dll_edge = 0;
  logic cke_lvl  = 1'b0;

  // ****************************************************************
  // link clock and commands
  // ****************************************************************
  initial
  begin
    ck_pin  = 1'b0;
    cke_pin = 1'b0;
    odt_pin = 1'b0;
    cmd_pin = 23'h7fffff;
    #37;
    forever #200 ck_pin = ~ck_pin;
  end

  always @(posedge ck_pin) ck_edges <= ck_edges + 1;

  task automatic issue(input logic [3:0] c, input logic [2:0] ba, input logic [15:0] a);
    @(negedge ck_pin);
    @(posedge clk_sys);
    cmd_pin <= {c, ba, a};
    cke_pin <= cke_lvl;
    cmd_edge = ck_edges + 1;
    @(negedge ck_pin);
    @(posedge clk_sys);
    cmd_pin <= {1'b1, ~c[2:0], ~ba, ~a};
    repeat (3) @(posedge clk_sys);
  endtask

  task automatic set_odt(input logic v);
    @(posedge clk_sys);
    odt_pin <= v;
  endtask

  task automatic load_ext1(input logic [15:0] a);
    set_odt(1'b0);
    issue(4'h0, 3'h1, a & 16'h1fff);
    repeat (8) @(posedge ck_pin);
  endtask

  task automatic self_refresh();
    set_odt(1'b0);
    cke_lvl = 1'b0;
    issue(4'h1, 3'h0, 16'h0000);
  endtask

  task automatic power_up(input logic fast);
    #200000;
    cke_lvl = 1'b1;
    @(posedge clk_sys);
    cke_pin <= 1'b1;
    #400;
    issue(4'h2, 3'h0, 16'h0400);
    issue(4'h0, 3'h2, {8'h00, fast, 7'h00});
    issue(4'h0, 3'h3, 16'h0000);
    issue(4'h0, 3'h1, 16'h0000);
    issue(4'h0, 3'h0, 16'h0100);
    dll_edge = cmd_edge;
    issue(4'h2, 3'h0, 16'h0400);
    repeat (2) issue(4'h1, 3'h0, 16'h0000);
    issue(4'h0, 3'h0, 16'h0030);
    issue(4'h0, 3'h1, 16'h0380);
    issue(4'h0, 3'h1, 16'h0000);
  endtask
endmodule

// >>> tb.sv
/*
  testbench of the mode register and initialization tracker.
  assumes the controller model drives the link side; clk_sys 20 MHz.
*/
`timescale 1ns/1ps

module tb;
  logic                          clk_sys = 1'b0;
  logic                          rstn    = 1'b0;
  logic                          ce      = 1'b1;
  logic                          ck_pin, cke_pin, odt_pin;
  ddr2_ext_mode_pkg::cmd_pins_t  cmd_pin;
  ddr2_ext_mode_pkg::rtt_t       rtt_sel_q;
  ddr2_ext_mode_pkg::latency_t   latency_q;
  ddr2_ext_mode_pkg::pwr_state_t pwr_state_q;
  logic                          term_on_q, al_reserved_q, refresh_fast_q, cal_default_q;
  logic                          col_issue_q, read_data_start_q, write_data_expect_q, ready_q;
  logic [1:0]                    rtt_tab [4] = '{2'h0, 2'h1, 2'h2, 2'h3};
  logic [15:0]                   exp_lat;
  int                            miscompares = 0;
  int                            tests_run   = 0;
  int                            cycles      = 0;
  int                            col_at, rd_at, wr_at, base, al, i;

  always #25 clk_sys = ~clk_sys;

  ddr2_ext_mode_init dut (.clk_sys(clk_sys), .rstn(rstn), .ce(ce), .ck_pin(ck_pin),
    .cke_pin(cke_pin), .odt_pin(odt_pin), .cmd_pin(cmd_pin), .rtt_sel_q(rtt_sel_q),
    .term_on_q(term_on_q), .latency_q(latency_q), .al_reserved_q(al_reserved_q),
    .refresh_fast_q(refresh_fast_q), .cal_default_q(cal_default_q),
    .col_issue_q(col_issue_q), .read_data_start_q(read_data_start_q),
    .write_data_expect_q(write_data_expect_q), .ready_q(ready_q), .pwr_state_q(pwr_state_q));

  mem_ctrl_model u_ctrl (.clk_sys(clk_sys), .ck_pin(ck_pin), .cke_pin(cke_pin),
    .odt_pin(odt_pin), .cmd_pin(cmd_pin));

  // ****************************************************************
  // pulse monitor, timeout and checks
  // ****************************************************************
  always @(posedge clk_sys)
  begin
    cycles++;
    if (col_issue_q === 1'b1) col_at = u_ctrl.ck_edges;
    if (read_data_start_q === 1'b1) rd_at = u_ctrl.ck_edges;
    if (write_data_expect_q === 1'b1) wr_at = u_ctrl.ck_edges;
    if (cycles == 20000)
    begin
      miscompares++;
      summarize();
    end
  end

  task automatic chk_flag(input string nm, input logic e, input logic g);
    tests_run++;
    if (g !== e)
    begin
      miscompares++;
      $display("Error %s expected %b seen %b", nm, e, g);
    end
  endtask

  task automatic chk_word(input string nm, input logic [15:0] e, input logic [15:0] g);
    tests_run++;
    if (g !== e)
    begin
      miscompares++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic wait_edge(input int n);
    while (u_ctrl.ck_edges < n) @(posedge clk_sys);
    repeat (5) @(posedge clk_sys);
  endtask

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // ****************************************************************
  // tests
  // ****************************************************************
  initial
  begin
    repeat (5) @(posedge clk_sys);
    rstn <= 1'b1;
    @(posedge clk_sys);
    chk_word("rtt_sel_q", 16'h0000, 16'(rtt_sel_q));
    chk_flag("cal_default_q", 1'b1, cal_default_q);
    chk_flag("ready_q", 1'b0, ready_q);
    chk_flag("refresh_fast_q", 1'b0, refresh_fast_q);
    chk_flag("al_reserved_q", 1'b0, al_reserved_q);
    $display("test reset done");
    u_ctrl.power_up(1'b1);
    chk_flag("refresh_fast_q", 1'b1, refresh_fast_q);
    chk_flag("cal_default_q", 1'b1, cal_default_q);
    chk_word("latency_q", 16'h0032, 16'(latency_q));
    wait_edge(u_ctrl.dll_edge + 199);
    chk_flag("ready_q", 1'b0, ready_q);
    wait_edge(u_ctrl.dll_edge + 200);
    chk_flag("ready_q", 1'b1, ready_q);
    $display("test power up done");
    for (i = 0; i < 4; i++)
    begin
      u_ctrl.load_ext1({9'h000, i[1], 3'h0, i[0], 2'h0});
      u_ctrl.set_odt(1'b1);
      repeat (6) @(posedge clk_sys);
      chk_word("rtt_sel_q", 16'(rtt_tab[i]), 16'(rtt_sel_q));
      chk_flag("term_on_q", i != 0, term_on_q);
    end
    u_ctrl.cke_lvl = 1'b0;
    u_ctrl.issue(4'hf, 3'h0, 16'h0000);
    chk_word("pwr_state_q", 16'h0001, 16'(pwr_state_q));
    chk_flag("term_on_q", 1'b1, term_on_q);
    u_ctrl.cke_lvl = 1'b1;
    u_ctrl.issue(4'hf, 3'h0, 16'h0000);
    chk_word("pwr_state_q", 16'h0000, 16'(pwr_state_q));
    u_ctrl.self_refresh();
    chk_word("pwr_state_q", 16'h0002, 16'(pwr_state_q));
    chk_flag("term_on_q", 1'b0, term_on_q);
    u_ctrl.set_odt(1'b1);
    repeat (6) @(posedge clk_sys);
    chk_flag("term_on_q", 1'b0, term_on_q);
    u_ctrl.cke_lvl = 1'b1;
    u_ctrl.issue(4'hf, 3'h0, 16'h0000);
    chk_word("pwr_state_q", 16'h0000, 16'(pwr_state_q));
    chk_flag("term_on_q", 1'b1, term_on_q);
    $display("test termination and power done");
    for (i = 0; i < 8; i++)
    begin
      u_ctrl.load_ext1(16'(i) << 3);
      al = (i == 7) ? 0 : i;
      exp_lat = {5'h00, al[2:0], al[3:0] + 4'h3, al[3:0] + 4'h2};
      chk_word("latency_q", exp_lat, 16'(latency_q));
      chk_flag("al_reserved_q", i == 7, al_reserved_q);
    end
    for (i = 0; i < 2; i++)
    begin
      al = i * 6;
      u_ctrl.load_ext1(16'(al) << 3);
      col_at = -1;
      rd_at = -1;
      u_ctrl.issue(4'h5, 3'h0, 16'h0000);
      base = u_ctrl.cmd_edge;
      wait_edge(base + al + 4);
      chk_word("col_issue edge", 16'(al), 16'(col_at - base));
      chk_word("read_data edge", 16'(al + 3), 16'(rd_at - base));
      rd_at = -1;
      wr_at = -1;
      u_ctrl.issue(4'h4, 3'h0, 16'h0000);
      base = u_ctrl.cmd_edge;
      wait_edge(base + al + 4);
      chk_word("write_data edge", 16'(al + 2), 16'(wr_at - base));
      chk_word("read_data after write", 16'hffff, 16'(rd_at));
    end
    $display("test latency done");
    u_ctrl.load_ext1(16'h0380);
    chk_flag("cal_default_q", 1'b0, cal_default_q);
    u_ctrl.load_ext1(16'h0000);
    chk_flag("cal_default_q", 1'b1, cal_default_q);
    chk_flag("refresh_fast_q", 1'b1, refresh_fast_q);
    @(posedge clk_sys);
    ce <= 1'b0;
    u_ctrl.load_ext1(16'h0004);
    @(posedge clk_sys);
    ce <= 1'b1;
    repeat (10) @(posedge clk_sys);
    chk_word("rtt_sel_q", 16'h0000, 16'(rtt_sel_q));
    $display("test hold done");
    summarize();
  end
endmodule
